// ==== core/lcd_ctrl_regs.svh ====
// Register map, field positions, reset values and timing for the display control
`ifndef LCD_CTRL_REGS_SVH
`define LCD_CTRL_REGS_SVH
// Register indexes; byte address is four times the index
`define IDX_BIAS 16'hF0F0
`define IDX_MODE 16'hF0F2
`define IDX_CTRL 16'hF0F4
`define IDX_SEGP 16'hF0F6
// Reset values
`define RST_BIAS 16'h0008
`define RST_MODE 16'h0040
`define RST_CTRL 16'h0000
`define RST_SEGP 16'h0000
// Bias control fields
`define BIT_PANEL 5
`define BIT_REV 4
`define BOOST_MSB 3
`define BOOST_LSB 1
`define BIT_BIAS_ON 0
// Display mode fields
`define BIT_WAVE 12
`define FRAME_MSB 7
`define FRAME_LSB 5
`define DUTY_MSB 3
`define DUTY_LSB 0
// Display control fields
`define VIEW_MSB 10
`define VIEW_LSB 8
`define STATE_MSB 1
`define STATE_LSB 0
// Field codes
`define LMD_STOP 2'h0
`define LMD_OFF 2'h1
`define LMD_SHOW 2'h2
`define LMD_ON 2'h3
`define DUTY_MAX 4'h8
`define DUTY_NIB 4'h4
`define VIEW_LOW 3'h0
`define VIEW_HIGH 3'h1
`define VIEW_1HZ 3'h2
`define VIEW_2HZ 3'h3
`define NIB_OFS 3'h4
`define FRAME_T32 3'h6
`define FRAME_T64 3'h7
// Low-speed clock 32768 Hz made from the 40 MHz system clock
`define LS_HZ 26'h0008000
`define CLK_HZ 26'h2625A00
// Frame lengths in low-speed ticks: 32, 38, 64, 75, 128, 150 Hz
`define DIV_32 11'h400
`define DIV_38 11'h35E
`define DIV_64 11'h200
`define DIV_75 11'h1B5
`define DIV_128 11'h100
`define DIV_150 11'h0DA
`endif

// ==== core/lcd_ctrl_pkg.sv ====
// Types shared by the segment display control block
package lcd_ctrl_pkg;
  // Overall display state
  typedef enum logic [1:0] {DS_STOP, DS_OFF, DS_SHOW, DS_ON} disp_state_t;
  // Bus data phase tracking
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_RWAIT, PH_RDATA} bus_phase_t;
endpackage

// ==== core/segment_lcd_driver_control.sv ====
// Segment display driver control with AHB-Lite register slave
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "lcd_ctrl_regs.svh"

module segment_lcd_driver_control import lcd_ctrl_pkg::*; (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic TICK_1HZ,
  input wire logic TICK_2HZ,
  input wire logic TICK_4HZ,
  input wire logic ADJ_TICK,
  input wire logic [15:0] DISP_ROW,
  output logic [2:0] DATA_ROW,
  output logic PANEL_LED,
  output logic REVERSE_VIEW,
  output logic BIAS_ON,
  output logic BOOST_TICK,
  output logic WAVE_FRAME,
  output logic DRIVE_POL,
  output logic DISP_STOP,
  output logic [7:0] COM_USED,
  output logic [7:0] COM_SEL,
  output logic [15:0] SEG_ON,
  output logic [15:0] PIN_IS_SEG
);

  localparam logic [15:0] BIAS_INIT = `RST_BIAS;
  localparam logic [15:0] MODE_INIT = `RST_MODE;
  localparam logic [15:0] CTRL_INIT = `RST_CTRL;
  localparam logic [15:0] SEGP_INIT = `RST_SEGP;

  logic panel_q, rev_q, bias_on_q, wave_q;
  logic [2:0] boost_q, frame_q, view_q;
  logic [3:0] duty_q;
  logic [1:0] lmd_q;
  logic [15:0] segp_q;
  bus_phase_t ph_q;
  logic [15:0] addr_q;
  logic hit_q;
  logic [31:0] hrdata_q;
  logic take, addr_ok, wr_en, stopped;
  logic [15:0] rd_word;
  disp_state_t state;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------

  // Address phase accepted whenever the bus is ready
  assign take = HSEL && HTRANS[1] && HREADY;
  assign addr_ok = (HADDR[31:18] == 14'h0000) && (HADDR[1:0] == 2'h0);

  // Reads take one wait state so a write just before is seen
  always_ff @(posedge CLK) begin
    if (RST) begin
      ph_q <= PH_IDLE;
    end else begin
      case (ph_q)
        PH_RWAIT: ph_q <= PH_RDATA;
        PH_IDLE, PH_WRITE, PH_RDATA: begin
          if (take) begin
            ph_q <= HWRITE ? PH_WRITE : PH_RWAIT;
          end else begin
            ph_q <= PH_IDLE;
          end
        end
        default: ph_q <= PH_IDLE;
      endcase
    end
  end

  // Address phase capture; HSIZE ignored, only word transfers used
  always_ff @(posedge CLK) begin
    if (RST) begin
      addr_q <= 16'h0000;
      hit_q <= 1'b0;
    end else if (take) begin
      addr_q <= HADDR[17:2];
      hit_q <= addr_ok;
    end
  end

  assign wr_en = (ph_q == PH_WRITE) && hit_q;
  assign stopped = (lmd_q == `LMD_STOP);

  // Read mux, unused and reserved bits stay zero
  always_comb begin
    rd_word = 16'h0000;
    if (hit_q) begin
      case (addr_q)
        `IDX_BIAS: begin
          rd_word[`BIT_PANEL] = panel_q;
          rd_word[`BIT_REV] = rev_q;
          rd_word[`BOOST_MSB:`BOOST_LSB] = boost_q;
          rd_word[`BIT_BIAS_ON] = bias_on_q;
        end
        `IDX_MODE: begin
          rd_word[`BIT_WAVE] = wave_q;
          rd_word[`FRAME_MSB:`FRAME_LSB] = frame_q;
          rd_word[`DUTY_MSB:`DUTY_LSB] = duty_q;
        end
        `IDX_CTRL: begin
          rd_word[`VIEW_MSB:`VIEW_LSB] = view_q;
          rd_word[`STATE_MSB:`STATE_LSB] = lmd_q;
        end
        `IDX_SEGP: rd_word = segp_q;
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // Read data registered in the wait cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      hrdata_q <= 32'h00000000;
    end else if (ph_q == PH_RWAIT) begin
      hrdata_q <= {16'h0000, rd_word};
    end
  end

  assign HRDATA = hrdata_q;
  assign HREADYOUT = (ph_q != PH_RWAIT);
  assign HRESP = 1'b0;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Bias control; whole low byte locked while the display runs
  always_ff @(posedge CLK) begin
    if (RST) begin
      panel_q <= BIAS_INIT[`BIT_PANEL];
      rev_q <= BIAS_INIT[`BIT_REV];
      boost_q <= BIAS_INIT[`BOOST_MSB:`BOOST_LSB];
      bias_on_q <= BIAS_INIT[`BIT_BIAS_ON];
    end else if (wr_en && (addr_q == `IDX_BIAS) && stopped) begin
      panel_q <= HWDATA[`BIT_PANEL];
      rev_q <= HWDATA[`BIT_REV];
      boost_q <= HWDATA[`BOOST_MSB:`BOOST_LSB];
      bias_on_q <= HWDATA[`BIT_BIAS_ON];
    end
  end

  // Display mode; waveform bit sits in the high byte, always writable
  always_ff @(posedge CLK) begin
    if (RST) begin
      wave_q <= MODE_INIT[`BIT_WAVE];
      frame_q <= MODE_INIT[`FRAME_MSB:`FRAME_LSB];
      duty_q <= MODE_INIT[`DUTY_MSB:`DUTY_LSB];
    end else if (wr_en && (addr_q == `IDX_MODE)) begin
      wave_q <= HWDATA[`BIT_WAVE];
      if (stopped) begin
        frame_q <= HWDATA[`FRAME_MSB:`FRAME_LSB];
        duty_q <= HWDATA[`DUTY_MSB:`DUTY_LSB];
      end
    end
  end

  // Display control and segment pin select
  always_ff @(posedge CLK) begin
    if (RST) begin
      view_q <= CTRL_INIT[`VIEW_MSB:`VIEW_LSB];
      lmd_q <= CTRL_INIT[`STATE_MSB:`STATE_LSB];
      segp_q <= SEGP_INIT;
    end else if (wr_en) begin
      if (addr_q == `IDX_CTRL) begin
        view_q <= HWDATA[`VIEW_MSB:`VIEW_LSB];
        lmd_q <= HWDATA[`STATE_MSB:`STATE_LSB];
      end
      if (addr_q == `IDX_SEGP) begin
        segp_q <= HWDATA[15:0];
      end
    end
  end

  // Display state decode
  always_comb begin
    case (lmd_q)
      `LMD_OFF: state = DS_OFF;
      `LMD_SHOW: state = DS_SHOW;
      `LMD_ON: state = DS_ON;
      default: state = DS_STOP;
    endcase
  end

  // ----------------------------------------------------------------
  // Time base and bias booster clock
  // ----------------------------------------------------------------

  logic [25:0] ls_acc_q, ls_sum;
  logic ls_tick_q;
  logic [6:0] boost_cnt_q, boost_mask;

  // Fractional divider; tick jitter of one system clock is harmless
  assign ls_sum = ls_acc_q + `LS_HZ;
  always_ff @(posedge CLK) begin
    if (RST) begin
      ls_acc_q <= 26'h0000000;
      ls_tick_q <= 1'b0;
    end else if (ls_sum >= `CLK_HZ) begin
      ls_acc_q <= ls_sum - `CLK_HZ;
      ls_tick_q <= 1'b1;
    end else begin
      ls_acc_q <= ls_sum;
      ls_tick_q <= 1'b0;
    end
  end

  // Boost pulse every 2^code low-speed ticks
  assign boost_mask = 7'((8'h01 << boost_q) - 8'h01);
  always_ff @(posedge CLK) begin
    if (RST) begin
      boost_cnt_q <= 7'h00;
    end else if (ls_tick_q) begin
      boost_cnt_q <= boost_cnt_q + 7'h01;
    end
  end

  // Booster only runs with the bias circuit enabled
  assign BOOST_TICK = bias_on_q && ls_tick_q && ((boost_cnt_q & boost_mask) == 7'h00);

  // ----------------------------------------------------------------
  // Frame and common scan
  // ----------------------------------------------------------------

  logic [3:0] duty_n;
  logic [10:0] frame_div, slot_acc_q;
  logic [11:0] slot_sum;
  logic src_tick, test_mode;
  logic [2:0] com_idx_q;
  logic pol_q;
  logic [7:0] com_mask;

  // Out-of-range duty codes drive no commons
  assign duty_n = (duty_q > `DUTY_MAX) ? 4'h0 : duty_q;
  assign com_mask = 8'((9'h001 << duty_n) - 9'h001);

  // Test codes count the adjusted time base instead
  assign test_mode = (frame_q == `FRAME_T32) || (frame_q == `FRAME_T64);
  assign src_tick = test_mode ? ADJ_TICK : ls_tick_q;

  // Frame length in source ticks
  always_comb begin
    case (frame_q)
      3'h0: frame_div = `DIV_32;
      3'h1: frame_div = `DIV_38;
      3'h2: frame_div = `DIV_64;
      3'h3: frame_div = `DIV_75;
      3'h4: frame_div = `DIV_128;
      3'h5: frame_div = `DIV_150;
      `FRAME_T32: frame_div = `DIV_32;
      default: frame_div = `DIV_64;
    endcase
  end

  // Frame split into duty slots by accumulating duty per tick
  assign slot_sum = {1'b0, slot_acc_q} + {8'h00, duty_n};
  always_ff @(posedge CLK) begin
    if (RST || stopped || (duty_n == 4'h0)) begin
      slot_acc_q <= 11'h000;
      com_idx_q <= 3'h0;
      pol_q <= 1'b0;
    end else if (src_tick) begin
      if (slot_sum >= {1'b0, frame_div}) begin
        slot_acc_q <= 11'(slot_sum - {1'b0, frame_div});
        if ({1'b0, com_idx_q} == (duty_n - 4'h1)) begin
          com_idx_q <= 3'h0;
          pol_q <= ~pol_q;
        end else begin
          com_idx_q <= com_idx_q + 3'h1;
          pol_q <= wave_q ? pol_q : ~pol_q;
        end
      end else begin
        slot_acc_q <= slot_sum[10:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Nibble view
  // ----------------------------------------------------------------

  logic t1_q, t2_q, t4_q, tick_fall, upper_q, upper, nib_en;

  // Falling edges of the time-base ticks
  always_ff @(posedge CLK) begin
    if (RST) begin
      t1_q <= 1'b0;
      t2_q <= 1'b0;
      t4_q <= 1'b0;
    end else begin
      t1_q <= TICK_1HZ;
      t2_q <= TICK_2HZ;
      t4_q <= TICK_4HZ;
    end
  end

  // Unlisted view codes fall back to the 4 Hz switching view
  always_comb begin
    case (view_q)
      `VIEW_1HZ: tick_fall = t1_q && !TICK_1HZ;
      `VIEW_2HZ: tick_fall = t2_q && !TICK_2HZ;
      default: tick_fall = t4_q && !TICK_4HZ;
    endcase
  end

  // Alternation only in the switching views
  always_ff @(posedge CLK) begin
    if (RST) begin
      upper_q <= 1'b0;
    end else if ((view_q > `VIEW_HIGH) && tick_fall) begin
      upper_q <= ~upper_q;
    end
  end

  assign nib_en = (duty_n != 4'h0) && (duty_n <= `DUTY_NIB);
  assign upper = (view_q == `VIEW_LOW) ? 1'b0 : ((view_q == `VIEW_HIGH) ? 1'b1 : upper_q);
  // Row address to the display data store, upper nibble offset by four
  assign DATA_ROW = com_idx_q + ((nib_en && upper) ? `NIB_OFS : 3'h0);

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------

  logic [7:0] com_used_q, com_sel_q;
  logic [15:0] seg_on_q, pin_seg_q;

  // Data row arrives in the same cycle; outputs line up one edge later
  always_ff @(posedge CLK) begin
    if (RST) begin
      com_used_q <= 8'h00;
      com_sel_q <= 8'h00;
      seg_on_q <= 16'h0000;
      pin_seg_q <= 16'h0000;
    end else begin
      com_used_q <= com_mask;
      // Commons 3 to 7 share pins with segments 0 to 4
      pin_seg_q <= segp_q & ~{11'h000, com_mask[7:3]};
      com_sel_q <= stopped ? 8'h00 : ((8'h01 << com_idx_q) & com_mask);
      case (state)
        DS_OFF: seg_on_q <= {16{rev_q}};
        DS_ON: seg_on_q <= {16{~rev_q}};
        DS_SHOW: seg_on_q <= DISP_ROW ^ {16{rev_q}};
        default: seg_on_q <= 16'h0000;
      endcase
    end
  end

  assign COM_USED = com_used_q;
  assign COM_SEL = com_sel_q;
  assign SEG_ON = seg_on_q;
  assign PIN_IS_SEG = pin_seg_q;
  assign PANEL_LED = panel_q;
  assign REVERSE_VIEW = rev_q;
  assign BIAS_ON = bias_on_q;
  assign WAVE_FRAME = wave_q;
  assign DRIVE_POL = pol_q;
  assign DISP_STOP = stopped;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence rd_req;
    HSEL && HTRANS[1] && HREADY && !HWRITE;
  endsequence

  sequence rd_done;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  a_read_wait: assert property (rd_req |=> rd_done)
    else $error("read data phase not one wait");

  a_mode_lock: assert property (
    wr_en && (addr_q == `IDX_MODE) && !stopped |=> $stable(frame_q) && $stable(duty_q))
    else $error("mode low byte written while running");

  a_bias_lock: assert property (
    wr_en && (addr_q == `IDX_BIAS) && !stopped |=> $stable(boost_q) && $stable(panel_q))
    else $error("bias low byte written while running");

  a_stop_low: assert property (stopped [*2] |-> (COM_SEL == 8'h00) && (SEG_ON == 16'h0000))
    else $error("pins not low while stopped");

  a_all_level: assert property (
    (state == DS_ON) && $stable(rev_q) |=> SEG_ON == {16{!$past(rev_q)}})
    else $error("all-on level wrong");

  a_show_data: assert property (
    state == DS_SHOW |=> SEG_ON == ($past(DISP_ROW) ^ {16{$past(rev_q)}}))
    else $error("shown data wrong");

  a_bad_duty: assert property ((duty_q > `DUTY_MAX) |=> COM_USED == 8'h00)
    else $error("commons used for bad duty");

  a_pin_prio: assert property ($past(duty_q) == `DUTY_MAX |-> PIN_IS_SEG[4:0] == 5'h00)
    else $error("shared pin left as segment");

  a_low_nibble: assert property (nib_en && (view_q == `VIEW_LOW) |-> DATA_ROW < `NIB_OFS)
    else $error("low view reads upper nibble");

  a_view_swap: assert property (
    (view_q == `VIEW_1HZ) && t1_q && !TICK_1HZ |=> upper_q != $past(upper_q))
    else $error("switching view did not alternate");

  a_boost_gate: assert property (BOOST_TICK |-> bias_on_q ##1 !BOOST_TICK [*8])
    else $error("boost pulse without bias or too fast");

endmodule

// ==== testbench/panel_model.sv ====
// Segment panel model: serves display data rows and watches common scanning
`timescale 1ns/1ps

module panel_model (
  input wire logic clk,
  input wire logic [2:0] data_row,
  input wire logic [7:0] com_sel,
  input wire logic [7:0] com_used,
  output logic [15:0] disp_row,
  output logic bad_scan
);
  // Every row differs, so a wrong row pick shows up on the segments
  assign disp_row = 16'hA5C3 ^ ({13'h0, data_row} * 16'h1357);

  // A common selected outside the used set would drive a dead pin
  always_ff @(posedge clk) begin
    bad_scan <= ($countones(com_sel) > 1) || ((com_sel & ~com_used) != 8'h00);
  end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the segment display control block
`timescale 1ns/1ps
`include "lcd_ctrl_regs.svh"

module tb import lcd_ctrl_pkg::*;;
  localparam logic [31:0] A_BIAS = {14'h0, `IDX_BIAS, 2'h0};
  localparam logic [31:0] A_MODE = {14'h0, `IDX_MODE, 2'h0};
  localparam logic [31:0] A_CTRL = {14'h0, `IDX_CTRL, 2'h0};
  localparam logic [31:0] A_SEGP = {14'h0, `IDX_SEGP, 2'h0};
  localparam logic [31:0] A_NONE = 32'h0003C3E0;
  logic CLK = 1'b0, RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, ADJ_TICK = 1'b0, adj_en = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2, tk = 3'h7, DATA_ROW;
  logic HREADYOUT, HRESP, PANEL_LED, REVERSE_VIEW, BIAS_ON, BOOST_TICK, WAVE_FRAME;
  logic DRIVE_POL, DISP_STOP, bad_scan, scan_bad = 1'b0, pol_q = 1'b0;
  logic [7:0] COM_USED, COM_SEL;
  logic [15:0] SEG_ON, PIN_IS_SEG, DISP_ROW;
  int fail_count = 0, n_compared = 0, cyc = 0, pol_n = 0, slot_len = 0;

  segment_lcd_driver_control dut (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TICK_1HZ(tk[0]),
    .TICK_2HZ(tk[1]), .TICK_4HZ(tk[2]), .ADJ_TICK(ADJ_TICK), .DISP_ROW(DISP_ROW),
    .DATA_ROW(DATA_ROW), .PANEL_LED(PANEL_LED), .REVERSE_VIEW(REVERSE_VIEW),
    .BIAS_ON(BIAS_ON), .BOOST_TICK(BOOST_TICK), .WAVE_FRAME(WAVE_FRAME),
    .DRIVE_POL(DRIVE_POL), .DISP_STOP(DISP_STOP), .COM_USED(COM_USED), .COM_SEL(COM_SEL),
    .SEG_ON(SEG_ON), .PIN_IS_SEG(PIN_IS_SEG));

  panel_model panel (.clk(CLK), .data_row(DATA_ROW), .com_sel(COM_SEL),
    .com_used(COM_USED), .disp_row(DISP_ROW), .bad_scan(bad_scan));

  // ----------------------------------------
  // Clock, time-base pulses and watchdogs
  // ----------------------------------------
  always #12.5 CLK = ~CLK;

  // Adjusted time base pulses every other cycle to keep test frames short
  always @(posedge CLK) begin
    ADJ_TICK <= adj_en & ~ADJ_TICK;
    pol_q <= DRIVE_POL;
    if (pol_q !== DRIVE_POL) pol_n++;
    if (bad_scan === 1'b1) scan_bad <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fail_count++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task end_sim;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One single AHB transfer; waits are bounded so a stuck slave cannot hang us
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1 && n < 50) begin
      @(posedge CLK);
      n++;
    end
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1 && n < 50) begin
      @(posedge CLK);
      n++;
    end
    q = HRDATA;
    HSEL <= 1'b0;
    // Let one edge pass so a following call never re-assigns the select in this step
    @(posedge CLK);
    if (n >= 50) chk(0, 1, "bus answer");
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
    repeat (3) @(posedge CLK);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, e, what);
  endtask

  task automatic cfg(input logic [15:0] bias, input logic [15:0] mode, input logic [15:0] ctl);
    wr(A_CTRL, 32'h0);
    wr(A_BIAS, {16'h0, bias});
    wr(A_MODE, {16'h0, mode});
    wr(A_CTRL, {16'h0, ctl});
  endtask

  function automatic logic [15:0] rowv(input int r);
    rowv = 16'hA5C3 ^ (16'(r) * 16'h1357);
  endfunction

  function automatic int idx(input logic [7:0] c);
    idx = 0;
    for (int k = 0; k < 8; k++) if (c[k]) idx = k;
  endfunction

  // Waits for the next common slot, then lets the outputs settle
  task automatic wait_slot;
    logic [7:0] c0;
    int n;
    c0 = COM_SEL;
    n = 0;
    while (COM_SEL === c0 && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    slot_len = n;
    if (n >= 3000) chk(0, 1, "common scan stuck");
    repeat (3) @(posedge CLK);
  endtask

  task automatic show_chk(input logic [1:0] st, input logic rev, input int ofs);
    logic [15:0] d, e;
    wait_slot;
    d = rowv(idx(COM_SEL) + ofs);
    case (st)
      2'h1: e = rev ? 16'hFFFF : 16'h0;
      2'h2: e = rev ? ~d : d;
      default: e = rev ? 16'h0 : 16'hFFFF;
    endcase
    chk({16'h0, SEG_ON}, {16'h0, e}, "segment drive");
  endtask

  task automatic get_ofs(output int o);
    wait_slot;
    o = (SEG_ON === rowv(idx(COM_SEL) + 4)) ? 4 : 0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rd_chk(A_BIAS, {16'h0, `RST_BIAS}, "bias reset");
    rd_chk(A_MODE, {16'h0, `RST_MODE}, "mode reset");
    rd_chk(A_CTRL, {16'h0, `RST_CTRL}, "ctrl reset");
    rd_chk(A_SEGP, {16'h0, `RST_SEGP}, "segsel reset");
    rd_chk(A_NONE, 32'h0, "unmapped read");
    chk({PANEL_LED, REVERSE_VIEW, BIAS_ON, WAVE_FRAME, DISP_STOP}, 5'h01, "reset out");
    chk({COM_USED, COM_SEL, PIN_IS_SEG}, 32'h0, "reset pins");
    chk({31'h0, HRESP}, 32'h0, "bus response okay");
  endtask

  // Field bits reach outputs; low byte locks once the display runs
  task t_bias;
    wr(A_BIAS, 32'h3F);
    rd_chk(A_BIAS, 32'h3F, "bias write");
    chk({PANEL_LED, REVERSE_VIEW, BIAS_ON}, 3'h7, "bias fields");
    wr(A_BIAS, 32'h1F);
    chk({PANEL_LED, REVERSE_VIEW, BIAS_ON}, 3'h3, "lcd select");
    wr(A_CTRL, 32'h1);
    wr(A_BIAS, 32'h0);
    rd_chk(A_BIAS, 32'h1F, "bias locked");
    wr(A_MODE, 32'h1000);
    rd_chk(A_MODE, 32'h1040, "mode locked");
    chk(WAVE_FRAME, 1'b1, "wave select");
    wr(A_CTRL, 32'h0);
    wr(A_BIAS, 32'h0);
    chk({PANEL_LED, REVERSE_VIEW, BIAS_ON}, 3'h0, "bias cleared");
  endtask

  task automatic t_boost;
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(A_BIAS, (c < 3) ? 32'(c << 1) | 32'h1 : 32'h0);
      n = 0;
      repeat (4883 << (c % 3)) begin
        @(posedge CLK);
        if (BOOST_TICK === 1'b1) n++;
      end
      if (c < 3) chk(n >= 3 && n <= 5, 1'b1, "boost rate");
      else chk(n, 0, "boost while off");
    end
  endtask

  task automatic t_fields;
    logic [7:0] u;
    wr(A_MODE, 32'hFFFF);
    rd_chk(A_MODE, 32'h10EF, "mode reserved");
    wr(A_CTRL, 32'hFFFC);
    rd_chk(A_CTRL, 32'h0700, "ctrl reserved");
    wr(A_CTRL, 32'h0);
    wr(A_SEGP, 32'hFFFF);
    rd_chk(A_SEGP, 32'hFFFF, "segsel write");
    for (int d = 0; d < 16; d++) begin
      wr(A_MODE, 32'(d));
      u = (d <= 8) ? 8'((9'h1 << d) - 9'h1) : 8'h0;
      chk(COM_USED, u, "commons used");
      chk(PIN_IS_SEG, 16'hFFFF & ~{11'h0, u[7:3]}, "pin routing");
    end
  endtask

  task automatic t_states;
    int n0;
    for (int r = 0; r < 2; r++) begin
      for (int s = 1; s < 4; s++) begin
        cfg({11'h0, r[0], 4'h8}, 16'h00E4, 16'(s));
        show_chk(2'(s), r[0], 0);
        show_chk(2'(s), r[0], 0);
      end
    end
    chk(slot_len >= 250 && slot_len <= 262, 1'b1, "64 Hz test slot");
    cfg(16'h8, 16'h00C4, 16'h2);
    wait_slot;
    wait_slot;
    chk(slot_len >= 506 && slot_len <= 518, 1'b1, "32 Hz test slot");
    for (int w = 0; w < 2; w++) begin
      cfg(16'h8, w ? 16'h10E4 : 16'h00E4, 16'h2);
      wait_slot;
      n0 = pol_n;
      repeat (4) wait_slot;
      chk(pol_n - n0, w ? 1 : 4, "drive reversal");
    end
    wr(A_CTRL, 32'h0);
    chk({COM_SEL, SEG_ON, 7'h0, DISP_STOP}, 32'h1, "stopped pins");
  endtask

  task automatic t_view;
    logic [2:0] vc [4] = '{3'h2, 3'h3, 3'h4, 3'h7};
    int rt [4] = '{0, 1, 2, 2};
    int o, o2;
    cfg(16'h8, 16'h00E4, 16'h0102);
    show_chk(2'h2, 1'b0, 4);
    cfg(16'h8, 16'h00E5, 16'h0102);
    show_chk(2'h2, 1'b0, 0);
    for (int i = 0; i < 4; i++) begin
      cfg(16'h8, 16'h00E4, {5'h0, vc[i], 8'h02});
      get_ofs(o);
      tk[(rt[i] == 0) ? 1 : 0] <= 1'b0;
      repeat (4) @(posedge CLK);
      tk <= 3'h7;
      get_ofs(o2);
      chk(o2, o, "other tick ignored");
      tk[rt[i]] <= 1'b0;
      repeat (4) @(posedge CLK);
      tk <= 3'h7;
      get_ofs(o2);
      chk(o2, 4 - o, "nibble switch");
    end
    wr(A_CTRL, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_reset;
    t_bias;
    t_boost;
    t_fields;
    adj_en <= 1'b1;
    t_states;
    t_view;
    chk(scan_bad, 1'b0, "scan outside commons");
    end_sim;
  end
endmodule
